// >>> seq_pkg.sv
// constants and carrier types for the three rail power sequencer
// assumes a single 50 MHz clock and synchronous active-high reset
package seq_pkg;
   // ==========================================================
   // clock and timing
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned TICK_US = 1;
   localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned DELAY_US = 30_000;
   localparam int unsigned REFRESH_US = 400;
   localparam int unsigned REARM_US = 120_000;
   localparam int CNT_W = 18;
   localparam logic [CNT_W-1:0] UP1_US = CNT_W'(DELAY_US + REFRESH_US);
   localparam logic [CNT_W-1:0] UP2_US = CNT_W'(DELAY_US);
   localparam logic [CNT_W-1:0] UP3_US = CNT_W'(DELAY_US);
   localparam logic [CNT_W-1:0] DN1_US = CNT_W'(DELAY_US + REFRESH_US);
   localparam logic [CNT_W-1:0] DN2_US = CNT_W'(DELAY_US);
   localparam logic [CNT_W-1:0] DN3_US = CNT_W'(DELAY_US);
   localparam logic [CNT_W-1:0] REARM_CNT = CNT_W'(REARM_US);
   localparam logic [CNT_W-1:0] CNT_RST = '0;
   localparam logic [2:0] RAIL_RST = 3'h0;

   // ==========================================================
   // states
   typedef enum logic [7:0] {
      ST_OFF = 8'h01,
      ST_UP1 = 8'h02,
      ST_UP2 = 8'h04,
      ST_UP3 = 8'h08,
      ST_ON = 8'h10,
      ST_DN1 = 8'h20,
      ST_DN2 = 8'h40,
      ST_DN3 = 8'h80
   } seq_state_e;

   typedef struct packed {
      logic out;
      logic oe_n;
   } od_pin_s;

   typedef struct packed {
      seq_state_e st;
      logic [CNT_W-1:0] cnt;
      logic [2:0] rail;
      logic rearm;
   } seq_reg_s;
endpackage

// >>> seq_tick.sv
// microsecond tick divider from the master clock
// assumes ref_clk at the rate in seq_pkg
`timescale 1ns/1ps
`default_nettype none
module seq_tick
   import seq_pkg::*;
#(
   parameter int unsigned TICK_LEN = TICK_CYC
)
(
   input wire logic ref_clk,
   input wire logic srst,
   output logic tick
);
   logic [5:0] div_q;
   logic [5:0] div_d;

   always_comb begin
      div_d = div_q + 6'h01;
      if (div_q == 6'(TICK_LEN - 1)) begin
         div_d = 6'h00;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         div_q <= 6'h00;
      end else begin
         div_q <= div_d;
      end
   end

   assign tick = (div_q == 6'(TICK_LEN - 1));
endmodule
`default_nettype wire

// >>> rail_sequencer.sv
// three rail power-up/power-down sequencer core
// assumes enable comparator output arrives asynchronously
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - one shared timer reloaded with six delays, three up, three down, and with the rearm wait
// - all rails low until enable seen
// - enable starts first delay, then rail one
// - each release starts next up delay
// - enable low pulls down rails three, two, one
// - down delays independent of up delays
// - enable drop before rail one resets
// - delays within fifteen/twenty percent tolerance
// - standard configuration uses first ordering
// - order up 1-2-3, down 3-2-1
// - late enable drop completes up, waits
// - late enable rise completes down, waits
// - all timers from one master tick
module rail_sequencer
   import seq_pkg::*;
#(
   // delay counts in ticks, defaults give the 30 ms option
   parameter logic [CNT_W-1:0] UP1_TICKS = UP1_US,
   parameter logic [CNT_W-1:0] UP2_TICKS = UP2_US,
   parameter logic [CNT_W-1:0] UP3_TICKS = UP3_US,
   parameter logic [CNT_W-1:0] DN1_TICKS = DN1_US,
   parameter logic [CNT_W-1:0] DN2_TICKS = DN2_US,
   parameter logic [CNT_W-1:0] DN3_TICKS = DN3_US,
   parameter logic [CNT_W-1:0] REARM_TICKS = REARM_CNT,
   parameter int unsigned TICK_LEN = TICK_CYC
)
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic seq_enable,
   output od_pin_s rail_release_out_1,
   output od_pin_s rail_release_out_2,
   output od_pin_s rail_release_out_3
);
   // ==========================================================
   // enable synchroniser
   logic en_meta_q;
   logic en_q;
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         en_meta_q <= 1'b0;
         en_q <= 1'b0;
      end else begin
         en_meta_q <= seq_enable;
         en_q <= en_meta_q;
      end
   end

   logic tick;
   seq_tick #(.TICK_LEN(TICK_LEN)) u_tick (
      .ref_clk(ref_clk),
      .srst(srst),
      .tick(tick)
   );

   // ==========================================================
   // sequencer state
   seq_reg_s s_q;
   seq_reg_s s_d;
   logic expired;
   assign expired = tick && (s_q.cnt == CNT_RST);

   always_comb begin
      s_d = s_q;
      if (tick && s_q.cnt != CNT_RST) begin
         s_d.cnt = s_q.cnt - CNT_W'(1);
      end
      case (s_q.st)
         ST_OFF: begin
            if (en_q) begin
               s_d.st = ST_UP1;
               s_d.cnt = s_q.rearm ? REARM_TICKS : UP1_TICKS;
               s_d.rearm = 1'b0;
            end
         end
         ST_UP1: begin
            if (!en_q) begin
               s_d.st = ST_OFF;
               s_d.cnt = CNT_RST;
            end else if (expired) begin
               if (s_q.rearm || s_q.cnt != CNT_RST) begin
                  s_d.rearm = 1'b0;
               end
               s_d.rail[0] = 1'b1;
               s_d.st = ST_UP2;
               s_d.cnt = UP2_TICKS;
            end
         end
         ST_UP2: begin
            if (!en_q && !s_q.rearm) begin
               s_d.rearm = 1'b1;
               s_d.cnt = UP2_TICKS;
            end
            if (expired) begin
               s_d.rail[1] = 1'b1;
               s_d.st = ST_UP3;
               s_d.cnt = UP3_TICKS;
            end
         end
         ST_UP3: begin
            if (!en_q && !s_q.rearm) begin
               s_d.rearm = 1'b1;
               s_d.cnt = UP3_TICKS;
            end
            if (expired) begin
               s_d.rail[2] = 1'b1;
               s_d.st = ST_ON;
               s_d.cnt = s_q.rearm || !en_q ? REARM_TICKS : CNT_RST;
            end
         end
         ST_ON: begin
            if (!en_q && (s_q.cnt == CNT_RST)) begin
               s_d.st = ST_DN1;
               s_d.cnt = DN1_TICKS;
               s_d.rearm = 1'b0;
            end
         end
         ST_DN1: begin
            if (en_q && !s_q.rearm) begin
               s_d.rearm = 1'b1;
               s_d.cnt = DN1_TICKS;
            end
            if (expired) begin
               s_d.rail[2] = 1'b0;
               s_d.st = ST_DN2;
               s_d.cnt = DN2_TICKS;
            end
         end
         ST_DN2: begin
            if (en_q && !s_q.rearm) begin
               s_d.rearm = 1'b1;
               s_d.cnt = DN2_TICKS;
            end
            if (expired) begin
               s_d.rail[1] = 1'b0;
               s_d.st = ST_DN3;
               s_d.cnt = DN3_TICKS;
            end
         end
         ST_DN3: begin
            if (en_q && !s_q.rearm) begin
               s_d.rearm = 1'b1;
               s_d.cnt = DN3_TICKS;
            end
            if (expired) begin
               s_d.rail[0] = 1'b0;
               s_d.st = ST_OFF;
               s_d.rearm = s_q.rearm || en_q;
               s_d.cnt = CNT_RST;
            end
         end
         default: begin
            s_d.st = ST_OFF;
            s_d.rail = RAIL_RST;
            s_d.cnt = CNT_RST;
            s_d.rearm = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_q.st <= ST_OFF;
         s_q.cnt <= CNT_RST;
         s_q.rail <= RAIL_RST;
         s_q.rearm <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // open-drain outputs, released means driver off
   assign rail_release_out_1 = '{out: 1'b0, oe_n: s_q.rail[0]};
   assign rail_release_out_2 = '{out: 1'b0, oe_n: s_q.rail[1]};
   assign rail_release_out_3 = '{out: 1'b0, oe_n: s_q.rail[2]};

   // ==========================================================
   // checks
   a_off_rails_low: assert property (@(posedge ref_clk) disable iff (srst)
      s_q.st == ST_OFF |-> s_q.rail == 3'h0) else $error("rails released while off");
   a_up_order: assert property (@(posedge ref_clk) disable iff (srst)
      s_q.rail[1] |-> s_q.rail[0]) else $error("rail two before rail one");
   a_up_order3: assert property (@(posedge ref_clk) disable iff (srst)
      s_q.rail[2] |-> s_q.rail[1]) else $error("rail three before rail two");
   a_sync_delay: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(en_q) |-> $past(seq_enable, 2)) else $error("enable not synchronised");
   a_glitch_reset: assert property (@(posedge ref_clk) disable iff (srst)
      (s_q.st == ST_UP1 && !s_q.rearm && !en_q) |=> s_q.st == ST_OFF)
      else $error("early drop not reset");
   a_rail1_timer: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(s_q.rail[0]) |-> $past(s_q.st) == ST_UP1 && $past(expired))
      else $error("rail one without timer");
   a_down_first: assert property (@(posedge ref_clk) disable iff (srst)
      $fell(s_q.rail[2]) |-> $past(s_q.st) == ST_DN1) else $error("rail three drop out of order");
   a_od_drive: assert property (@(posedge ref_clk) disable iff (srst)
      !s_q.rail[0] |-> !rail_release_out_1.oe_n && !rail_release_out_1.out)
      else $error("unreleased rail not pulled low");
   a_down_order2: assert property (@(posedge ref_clk) disable iff (srst)
      $fell(s_q.rail[1]) |-> $past(s_q.st) == ST_DN2)
      else $error("rail two drop out of order");
   a_rail1_drop: assert property (@(posedge ref_clk) disable iff (srst)
      $fell(s_q.rail[0]) |-> $past(s_q.st) == ST_DN3 && $past(expired))
      else $error("rail one drop without timer");
   a_late_drop_restart: assert property (@(posedge ref_clk) disable iff (srst)
      (s_q.st == ST_UP2 && !s_q.rearm && !en_q && !expired)
      |=> s_q.cnt == UP2_TICKS && s_q.rearm)
      else $error("late drop did not restart timer");
   a_rearm_hold: assert property (@(posedge ref_clk) disable iff (srst)
      (s_q.st == ST_ON && s_q.cnt != CNT_RST) |=> s_q.st == ST_ON)
      else $error("power-down started before rearm wait");
   a_late_rise_restart: assert property (@(posedge ref_clk) disable iff (srst)
      (s_q.st == ST_DN2 && !s_q.rearm && en_q && !expired)
      |=> s_q.cnt == DN2_TICKS && s_q.rearm)
      else $error("late rise did not restart timer");
endmodule
`default_nettype wire

// >>> reg_enable_model.sv
// enable inputs of three regulators behind open-drain flags
// assumes a pull-up on every enable line
`timescale 1ns/1ps
`default_nettype none
module reg_enable_model
   import seq_pkg::*;
(
   input wire od_pin_s rail_1,
   input wire od_pin_s rail_2,
   input wire od_pin_s rail_3,
   output logic [2:0] en_lvl
);
   // ====
   // pull-up wins when driver is off
   assign en_lvl[0] = rail_1.oe_n ? 1'b1 : rail_1.out;
   assign en_lvl[1] = rail_2.oe_n ? 1'b1 : rail_2.out;
   assign en_lvl[2] = rail_3.oe_n ? 1'b1 : rail_3.out;
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the rail sequencer
// assumes shrunk delays handed to the core, one 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import seq_pkg::*;
   // shrunk delays in ticks: up 20 and down 32 nominal, 4 of refresh, 50 of rearm
   localparam logic [CNT_W-1:0] SIM_UP1 = 18'h18;
   localparam logic [CNT_W-1:0] SIM_UP2 = 18'h14;
   localparam logic [CNT_W-1:0] SIM_DN1 = 18'h24;
   localparam logic [CNT_W-1:0] SIM_DN2 = 18'h20;
   localparam logic [CNT_W-1:0] SIM_REARM = 18'h32;
   localparam int unsigned DA = 32'(SIM_UP1) * TICK_CYC;
   localparam int unsigned DB = 32'(SIM_UP2) * TICK_CYC;
   localparam int unsigned DC = 32'(SIM_DN1) * TICK_CYC;
   localparam int unsigned DD = 32'(SIM_DN2) * TICK_CYC;
   localparam int unsigned DR = 32'(SIM_REARM) * TICK_CYC;
   logic ref_clk, srst, seq_enable;
   od_pin_s r1, r2, r3;
   logic [2:0] lvl;
   int err_count, compares;
   rail_sequencer #(.UP1_TICKS(SIM_UP1), .UP2_TICKS(SIM_UP2), .UP3_TICKS(SIM_UP2),
      .DN1_TICKS(SIM_DN1), .DN2_TICKS(SIM_DN2), .DN3_TICKS(SIM_DN2),
      .REARM_TICKS(SIM_REARM), .TICK_LEN(TICK_CYC))
      i_dut (.ref_clk(ref_clk), .srst(srst), .seq_enable(seq_enable),
      .rail_release_out_1(r1), .rail_release_out_2(r2), .rail_release_out_3(r3));
   reg_enable_model i_reg (.rail_1(r1), .rail_2(r2), .rail_3(r3), .en_lvl(lvl));
   // ====
   // clock and helpers
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task step(input logic [2:0] exp, input int unsigned cyc, input int unsigned tol);
      logic [2:0] cur;
      int unsigned n;
      cur = lvl;
      n = 0;
      while (lvl === cur && n < cyc + tol + 10) begin
         @(negedge ref_clk);
         n++;
      end
      check(32'(lvl), 32'(exp));
      check(32'(n + tol >= cyc && n <= cyc + tol), 32'h1);
   endtask
   task close_out();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ====
   // scenarios
   task t_reset();
      repeat (10) @(negedge ref_clk);
      check(32'(lvl), 32'h0);
      srst = 1'b0;
      repeat (1000) @(negedge ref_clk);
      check(32'(lvl), 32'h0);
      $display("reset test done");
   endtask
   task t_glitch();
      seq_enable = 1'b1;
      repeat (DA / 2) @(negedge ref_clk);
      seq_enable = 1'b0;
      repeat (DA) @(negedge ref_clk);
      check(32'(lvl), 32'h0);
      $display("glitch test done");
   endtask
   task t_up();
      seq_enable = 1'b1;
      step(3'h1, DA, 100);
      step(3'h3, DB, 100);
      step(3'h7, DB, 100);
      $display("power-up test done");
   endtask
   task t_down();
      seq_enable = 1'b0;
      step(3'h3, DC, 100);
      step(3'h1, DD, 100);
      step(3'h0, DD, 100);
      $display("power-down test done");
   endtask
   task t_late_rise();
      seq_enable = 1'b0;
      step(3'h3, DC, 100);
      seq_enable = 1'b1;
      step(3'h1, DD, 100);
      step(3'h0, DD, 100);
      step(3'h1, DR, 100);
      step(3'h3, DB, 100);
      step(3'h7, DB, 100);
      $display("late rise test done");
   endtask
   task t_late_drop();
      seq_enable = 1'b1;
      step(3'h1, DA, 100);
      seq_enable = 1'b0;
      step(3'h3, DB, 100);
      step(3'h7, DB, 100);
      step(3'h3, DR + DC, 100);
      step(3'h1, DD, 100);
      step(3'h0, DD, 100);
      $display("late drop test done");
   endtask
   // ====
   // main sequence and watchdog
   initial begin
      err_count = 0;
      compares = 0;
      srst = 1'b1;
      seq_enable = 1'b0;
      t_reset();
      t_glitch();
      t_up();
      t_late_rise();
      t_down();
      t_late_drop();
      close_out();
   end
   initial begin
      #1_500_000;
      err_count++;
      close_out();
   end
endmodule
`default_nettype wire
